// [inc/usart_frame_defines.svh]
/*
 * Offsets, field positions and reset values of the serial frame path.
 * Assumes inclusion by bare name from the design file, the checker and the bench.
 */
`ifndef USART_FRAME_DEFINES_SVH
`define USART_FRAME_DEFINES_SVH

// =============================================================================
// Register offsets
`define ADDR_DATA       3'h0
`define ADDR_STATUS     3'h1
`define ADDR_CONTROL    3'h2
`define ADDR_FORMAT     3'h3
`define ADDR_BAUD       3'h4

// =============================================================================
// Status register bits
`define ST_RXC          7
`define ST_TXC          6
`define ST_UDRE         5
`define ST_FE           4
`define ST_DOR          3
`define ST_PE           2

// =============================================================================
// Control register bits
`define CT_RXCIE        7
`define CT_TX_DONE_IRQ_ENABLE        6
`define CT_UDRIE        5
`define CT_RECEIVE_ENABLE         4
`define CT_TRANSMIT_ENABLE         3
`define CT_RX9          2
`define CT_TX9          0

// =============================================================================
// Format register bits
`define FM_SYNC         6
`define FM_PAR_EN       5
`define FM_PAR_ODD      4
`define FM_TWO_STOP     3
`define FM_SIZE_LSB     0

// =============================================================================
// Reset values and the nine-bit size code
`define RST_CONTROL     8'h00
`define RST_FORMAT      8'h06
`define RST_BAUD        16'h0000
`define SIZE_NINE       3'h7

`endif

// [inc/usart_frame_pkg.sv]
/*
 * Types of the serial frame path.
 * Assumes the defines header is on the include path.
 */
package usart_frame_pkg;

    // =========================================================================
    // Shifter states
    typedef enum logic [4:0] {
        SH_IDLE  = 5'b00001,
        SH_START = 5'b00010,
        SH_DATA  = 5'b00100,
        SH_PAR   = 5'b01000,
        SH_STOP  = 5'b10000
    } shift_state_e;

endpackage : usart_frame_pkg

// [rtl/usart_frame_path.sv]
/*
 * Serial transmitter and receiver frame path with a two-entry receive FIFO.
 * Assumes a CPU port with one-cycle strobes and read data one cycle later,
 * and a remote transceiver on the serial pins; global interrupt enable
 * arrives from the core, service acknowledge pulses from it.
 */
// Added by the designer: the plain strobed port and the register addresses.
// Notes on behaviour
// [RULE1] Request tx-done interrupt when flag and enables set
// [RULE2] Servicing tx-done interrupt clears its flag
// [RULE3] Parity bit follows data, before first stop
// [RULE4] Transmit disable waits until shifter and buffer empty
// [RULE5] Disabled transmitter releases the output pin
// [RULE6] Receive enable takes over the input pin
// [RULE7] Synchronous mode samples on external transfer clock
// [RULE8] Frame starts on valid start bit, shifts
// [RULE9] Second stop bit ignored by receiver
// [RULE10] First stop bit moves frame into buffer
// [RULE11] Unused high data bits read as zero
// [RULE12] Software reads ninth bit before data byte
// [RULE13] Software reads error flags before data byte
// [RULE14] Ninth bit and errors stored per entry
// [RULE15] Data read frees the entry at once
// [RULE16] Half-duplex software releases bus after completion
// [RULE17] Tx-done set when shifter and buffer empty
// [RULE18] Receive-complete shows unread buffered data
// [RULE19] Odd/even select applies to generation and check
// [RULE20] Receive buffer holds two characters
// [RULE21] Even parity is XOR; odd its inverse
`timescale 1ns/100ps
`include "usart_frame_defines.svh"

module usart_frame_path
    import usart_frame_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // CPU register port
    input  wire logic [2:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Interrupt handshake with the core
    input  wire logic        i_global_irq_enable,
    input  wire logic        i_tx_done_irq_ack,
    output logic             o_tx_done_irq,
    output logic             o_rx_irq,
    output logic             o_udre_irq,
    // Serial pins
    input  wire logic        i_rxd,
    input  wire logic        i_transfer_clock_pin,
    output logic             o_txd,
    output logic             o_txd_oe,
    output logic             o_rxd_owned
);

    // =========================================================================
    // Helpers
    function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
        logic p;
        p = odd;
        for (int k = 0; k < 9; k++) begin
            if (k < int'(n)) p = p ^ d[k];
        end
        return p; // [RULE21] [RULE19]
    endfunction : parity_of

    // Reserved size codes fall back to eight data bits.
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        if (code == `SIZE_NINE) return 4'd9;
        if (code[2]) return 4'd8;
        return 4'd5 + {2'b00, code[1:0]};
    endfunction : data_bits

    // =========================================================================
    // Registers
    logic [7:0]   control_reg, control_next;
    logic [7:0]   format_reg, format_next;
    logic [15:0]  baud_reg, baud_next;
    logic [15:0]  bcnt_reg, bcnt_next;
    logic [2:0]   rx_s1_reg, rx_s2_reg, rx_s3_reg, xk_s1_reg, xk_s2_reg, xk_s3_reg;
    logic         rx_pin, xk_pin, xk_prev_reg, rx_hold_reg;
    logic [8:0]   txbuf_reg, txbuf_next;
    logic         txfull_reg, txfull_next, txc_reg, txc_next, txact_reg, txact_next;
    shift_state_e tst_reg, tst_next;
    logic [8:0]   tsh_reg, tsh_next;
    logic [3:0]   tcnt_reg, tcnt_next;
    logic         tpar_reg, tpar_next, txd_reg, txd_next;
    shift_state_e rst_reg, rst_next;
    logic [8:0]   rsh_reg, rsh_next;
    logic [3:0]   rcnt_reg, rcnt_next;
    logic         rpar_reg, rpar_next, dor_pend_reg, dor_pend_next;
    logic [11:0]  fifo_mem [FIFO_DEPTH];
    logic [11:0]  fifo_wdat;
    logic [$clog2(FIFO_DEPTH+1)-1:0] fcnt_reg, fcnt_next;
    logic         push, pop, tick, tx_tick, rx_tick, sync_mode;
    logic [3:0]   nbits;
    logic [7:0]   rdata_reg, rdata_next;

    // Input pins: three flops, a change counts once stages two and three agree.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_s1_reg   <= 3'h7;
            xk_s1_reg   <= 3'h0;
            xk_prev_reg <= 1'b0;
            rx_hold_reg <= 1'b1;
        end else begin
            rx_s1_reg   <= {rx_s1_reg[1:0], i_rxd};
            xk_s1_reg   <= {xk_s1_reg[1:0], i_transfer_clock_pin};
            xk_prev_reg <= xk_pin;
            rx_hold_reg <= rx_pin;
        end
    end
    assign rx_s2_reg = rx_s1_reg;
    assign xk_s2_reg = xk_s1_reg;
    assign rx_s3_reg = rx_s1_reg;
    assign xk_s3_reg = xk_s1_reg;
    assign rx_pin = (rx_s2_reg[1] == rx_s3_reg[2]) ? rx_s3_reg[2] : rx_hold_reg;
    assign xk_pin = (xk_s2_reg[1] == xk_s3_reg[2]) ? xk_s3_reg[2] : xk_prev_reg;

    assign sync_mode = format_reg[`FM_SYNC];
    assign nbits     = data_bits(format_reg[`FM_SIZE_LSB +: 3]);
    assign tick      = (bcnt_reg == 16'h0000);
    assign tx_tick   = sync_mode ? (xk_pin & ~xk_prev_reg) : tick;
    assign rx_tick   = sync_mode ? (xk_pin & ~xk_prev_reg) : tick; // [RULE7]

    // =========================================================================
    // Register file, transmit path and receive path
    always_comb begin
        control_next  = control_reg;
        format_next   = format_reg;
        baud_next     = baud_reg;
        bcnt_next     = tick ? baud_reg : bcnt_reg - 16'h0001;
        txbuf_next    = txbuf_reg;
        txfull_next   = txfull_reg;
        txc_next      = txc_reg;
        txact_next    = txact_reg;
        tst_next      = tst_reg;
        tsh_next      = tsh_reg;
        tcnt_next     = tcnt_reg;
        tpar_next     = tpar_reg;
        txd_next      = txd_reg;
        rst_next      = rst_reg;
        rsh_next      = rsh_reg;
        rcnt_next     = rcnt_reg;
        rpar_next     = rpar_reg;
        dor_pend_next = dor_pend_reg;
        push          = 1'b0;
        fifo_wdat     = 12'h000;
        rdata_next    = 8'h00;
        pop = i_rd && (i_addr == `ADDR_DATA) && (fcnt_reg != '0); // [RULE15]
        if (i_wr) begin
            case (i_addr)
                `ADDR_DATA: if (txact_reg) begin
                    txbuf_next  = {control_reg[`CT_TX9], i_wdata};
                    txfull_next = 1'b1;
                end
                `ADDR_STATUS: if (i_wdata[`ST_TXC]) txc_next = 1'b0;
                `ADDR_CONTROL: control_next = i_wdata;
                `ADDR_FORMAT: format_next = i_wdata;
                `ADDR_BAUD: baud_next = {baud_reg[15:8], i_wdata};
                default: baud_next = {i_wdata, baud_reg[7:0]};
            endcase
        end
        if (i_tx_done_irq_ack) txc_next = 1'b0; // [RULE2]
        // Transmitter stays active while anything is still to be sent.
        if (control_reg[`CT_TRANSMIT_ENABLE]) txact_next = 1'b1;
        else if (!txfull_reg && tst_reg == SH_IDLE) txact_next = 1'b0; // [RULE4]
        if (tx_tick) begin
            case (tst_reg)
                SH_IDLE: if (txfull_reg) begin
                    tsh_next    = txbuf_reg;
                    tpar_next   = parity_of(txbuf_reg, nbits, format_reg[`FM_PAR_ODD]);
                    txfull_next = 1'b0;
                    txd_next    = 1'b0;
                    tcnt_next   = 4'd0;
                    tst_next    = SH_DATA;
                end
                SH_DATA: begin
                    txd_next  = tsh_reg[0];
                    tsh_next  = {1'b0, tsh_reg[8:1]};
                    tcnt_next = tcnt_reg + 4'd1;
                    if (tcnt_reg + 4'd1 == nbits)
                        tst_next = format_reg[`FM_PAR_EN] ? SH_PAR : SH_STOP;
                end
                SH_PAR: begin
                    txd_next = tpar_reg; // [RULE3]
                    tst_next = SH_STOP;
                end
                SH_STOP: begin
                    txd_next  = 1'b1;
                    tcnt_next = tcnt_reg + 4'd1;
                    // The frame ends one tick after the last stop bit began.
                    if (tcnt_reg == nbits + {3'b000, format_reg[`FM_TWO_STOP]} + 4'd1) begin
                        tst_next = SH_IDLE;
                        if (!txfull_reg) txc_next = 1'b1; // [RULE17]
                    end
                end
                default: tst_next = SH_IDLE;
            endcase
        end
        if (!control_reg[`CT_RECEIVE_ENABLE]) begin
            rst_next = SH_IDLE;
        end else if (rx_tick) begin
            case (rst_reg)
                SH_IDLE: if (!rx_pin) begin // [RULE8]
                    rst_next  = SH_DATA;
                    rcnt_next = 4'd0;
                    rsh_next  = 9'h000; // [RULE11]
                    if (fcnt_reg == FIFO_DEPTH[$bits(fcnt_reg)-1:0] && !pop)
                        dor_pend_next = 1'b1;
                end
                SH_DATA: begin
                    rsh_next  = rsh_reg | ({8'h00, rx_pin} << rcnt_reg);
                    rcnt_next = rcnt_reg + 4'd1;
                    if (rcnt_reg + 4'd1 == nbits)
                        rst_next = format_reg[`FM_PAR_EN] ? SH_PAR : SH_STOP;
                end
                SH_PAR: begin
                    rpar_next = rx_pin ^ parity_of(rsh_reg, nbits, format_reg[`FM_PAR_ODD]);
                    rst_next  = SH_STOP;
                end
                SH_STOP: begin
                    // Only the first stop bit is looked at. [RULE9]
                    rst_next  = SH_IDLE;
                    push      = 1'b1; // [RULE10]
                    fifo_wdat = {dor_pend_reg, ~rx_pin,
                                 format_reg[`FM_PAR_EN] & rpar_reg, rsh_reg}; // [RULE14]
                    // A dropped frame keeps the overrun pending for the next stored one.
                    if (fcnt_reg != FIFO_DEPTH[$bits(fcnt_reg)-1:0] || pop)
                        dor_pend_next = 1'b0;
                    rpar_next = 1'b0;
                end
                default: rst_next = SH_IDLE;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `ADDR_DATA: rdata_next = (fcnt_reg != '0) ? fifo_mem[0][7:0] : 8'h00;
                `ADDR_STATUS: rdata_next = {fcnt_reg != '0, txc_reg, ~txfull_reg,
                    (fcnt_reg != '0) ? fifo_mem[0][10] : 1'b0,
                    (fcnt_reg != '0) ? fifo_mem[0][11] : 1'b0,
                    (fcnt_reg != '0) ? fifo_mem[0][9] : 1'b0, 2'b00}; // [RULE18]
                `ADDR_CONTROL: rdata_next = {control_reg[7:3],
                    (fcnt_reg != '0) ? fifo_mem[0][8] : 1'b0, 1'b0, control_reg[0]};
                `ADDR_FORMAT: rdata_next = format_reg;
                `ADDR_BAUD: rdata_next = baud_reg[7:0];
                3'h5: rdata_next = baud_reg[15:8];
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Receive FIFO: entry 0 is the head; a full FIFO drops the new frame.
    always_comb begin
        fcnt_next = fcnt_reg;
        if (!control_next[`CT_RECEIVE_ENABLE]) fcnt_next = '0;
        else if (push && !pop && fcnt_reg != FIFO_DEPTH[$bits(fcnt_reg)-1:0])
            fcnt_next = fcnt_reg + 1'b1; // [RULE20]
        else if (pop && !push) fcnt_next = fcnt_reg - 1'b1;
    end

    always_ff @(posedge i_clk) begin
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            if (pop && push && k == int'(fcnt_reg) - 1) fifo_mem[k] <= fifo_wdat;
            else if (pop) fifo_mem[k] <= (k + 1 < FIFO_DEPTH) ? fifo_mem[k + 1] : 12'h000;
            else if (push && k == int'(fcnt_reg)) fifo_mem[k] <= fifo_wdat;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            control_reg  <= `RST_CONTROL;
            format_reg   <= `RST_FORMAT;
            baud_reg     <= `RST_BAUD;
            bcnt_reg     <= `RST_BAUD;
            txbuf_reg    <= 9'h000;
            txfull_reg   <= 1'b0;
            txc_reg      <= 1'b0;
            txact_reg    <= 1'b0;
            tst_reg      <= SH_IDLE;
            tsh_reg      <= 9'h000;
            tcnt_reg     <= 4'd0;
            tpar_reg     <= 1'b0;
            txd_reg      <= 1'b1;
            rst_reg      <= SH_IDLE;
            rsh_reg      <= 9'h000;
            rcnt_reg     <= 4'd0;
            rpar_reg     <= 1'b0;
            dor_pend_reg <= 1'b0;
            fcnt_reg     <= '0;
            rdata_reg    <= 8'h00;
        end else begin
            control_reg  <= control_next;
            format_reg   <= format_next;
            baud_reg     <= baud_next;
            bcnt_reg     <= bcnt_next;
            txbuf_reg    <= txbuf_next;
            txfull_reg   <= txfull_next;
            txc_reg      <= txc_next;
            txact_reg    <= txact_next;
            tst_reg      <= tst_next;
            tsh_reg      <= tsh_next;
            tcnt_reg     <= tcnt_next;
            tpar_reg     <= tpar_next;
            txd_reg      <= txd_next;
            rst_reg      <= rst_next;
            rsh_reg      <= rsh_next;
            rcnt_reg     <= rcnt_next;
            rpar_reg     <= rpar_next;
            dor_pend_reg <= dor_pend_next;
            fcnt_reg     <= fcnt_next;
            rdata_reg    <= rdata_next;
        end
    end

    // =========================================================================
    // Outputs
    assign o_rdata       = rdata_reg;
    assign o_tx_done_irq = txc_reg & control_reg[`CT_TX_DONE_IRQ_ENABLE] & i_global_irq_enable; // [RULE1]
    assign o_rx_irq      = (fcnt_reg != '0) & control_reg[`CT_RXCIE] & i_global_irq_enable;
    assign o_udre_irq    = ~txfull_reg & control_reg[`CT_UDRIE] & i_global_irq_enable;
    assign o_txd         = txd_reg;
    assign o_txd_oe      = txact_reg;                // [RULE5]
    assign o_rxd_owned   = control_reg[`CT_RECEIVE_ENABLE];    // [RULE6]

endmodule : usart_frame_path

// [verification/usart_frame_chk.sv]
/* Port checker for the serial frame path.
   Assumes it is bound to every instance of usart_frame_path. */
`timescale 1ns/100ps
`include "usart_frame_defines.svh"

module usart_frame_chk (
    // Clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Interrupts and pins
    input wire logic       i_global_irq_enable,
    input wire logic       i_tx_done_irq_ack,
    input wire logic       o_tx_done_irq,
    input wire logic       o_rx_irq,
    input wire logic       o_txd,
    input wire logic       o_txd_oe,
    input wire logic       o_rxd_owned
);
    logic [7:0] ctl_reg, ctl_next;
    logic [2:0] size_reg, size_next;

    // =========================================================================
    // Shadow copies of the control byte and the character size code.
    always_comb begin
        ctl_next  = (i_wr && i_addr == `ADDR_CONTROL) ? i_wdata : ctl_reg;
        size_next = (i_wr && i_addr == `ADDR_FORMAT) ? i_wdata[2:0] : size_reg;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_reg  <= `RST_CONTROL;
            size_reg <= 3'h6;
        end else begin
            ctl_reg  <= ctl_next;
            size_reg <= size_next;
        end
    end

    // =========================================================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_irq_gated:
    assert property (o_tx_done_irq |-> ctl_reg[`CT_TX_DONE_IRQ_ENABLE] && i_global_irq_enable)
        else $error("tx done irq without enables");
    a_ack_clears:
    assert property (i_tx_done_irq_ack && o_tx_done_irq |=> !o_tx_done_irq)
        else $error("tx done irq survived its acknowledge");
    a_oe_in_frame:
    assert property (!o_txd |-> o_txd_oe)
        else $error("line driven low without ownership");
    a_line_idle:
    assert property (!o_txd_oe |-> o_txd)
        else $error("released line not idle high");
    a_rx_owned:
    assert property (i_wr && i_addr == `ADDR_CONTROL |=> o_rxd_owned == $past(i_wdata[`CT_RECEIVE_ENABLE]))
        else $error("input pin ownership does not follow enable");
    a_short_char:
    assert property ($past(i_rd && i_addr == `ADDR_DATA) && size_reg == 3'h0 |-> o_rdata[7:5] == 3'h0)
        else $error("unused high data bits not zero");
    a_rx_gated:
    assert property (o_rx_irq |-> ctl_reg[`CT_RXCIE] && i_global_irq_enable && o_rxd_owned)
        else $error("rx irq without enables");
    a_flush:
    assert property (i_wr && i_addr == `ADDR_CONTROL && !i_wdata[`CT_RECEIVE_ENABLE] |=> ##1 !o_rx_irq)
        else $error("receive disable did not empty the buffer");

    c_tx_done: cover property ($rose(o_tx_done_irq));
    c_rx_data: cover property ($rose(o_rx_irq));
    c_released: cover property ($fell(o_txd_oe));
endmodule : usart_frame_chk

bind usart_frame_path usart_frame_chk usart_frame_chk_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
    .i_tx_done_irq_ack(i_tx_done_irq_ack), .o_tx_done_irq(o_tx_done_irq),
    .o_rx_irq(o_rx_irq), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_rxd_owned(o_rxd_owned)
);

// [verification/usart_remote.sv]
/* Model of the remote serial transceiver on the data pins.
   Assumes a bit lasts BIT system clocks, matching the baud setting. */
`timescale 1ns/100ps

module usart_remote #(
    parameter int BIT = 4
) (
    // Clock and serial pins
    input  wire logic i_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    logic [8:0] got_bits;
    int         got_count = 0;

    initial o_rxd = 1'b1;

    // =========================================================================
    // Sends start, n data bits LSB first, an optional parity bit and a stop bit.
    task automatic send(input logic [8:0] d, input int n, input logic pe, input logic pv,
                        input logic stop);
        o_rxd <= 1'b0;
        repeat (BIT) @(posedge i_clk);
        for (int k = 0; k < n; k++) begin
            o_rxd <= d[k];
            repeat (BIT) @(posedge i_clk);
        end
        if (pe) begin
            o_rxd <= pv;
            repeat (BIT) @(posedge i_clk);
        end
        o_rxd <= stop;
        repeat (BIT) @(posedge i_clk);
        o_rxd <= 1'b1;
        repeat (3 * BIT) @(posedge i_clk);
    endtask : send

    // Samples each sent frame at mid-bit: eight data bits, then parity or stop.
    initial forever begin
        @(negedge i_txd);
        repeat (BIT / 2) @(posedge i_clk);
        for (int k = 0; k < 9; k++) begin
            repeat (BIT) @(posedge i_clk);
            got_bits[k] = i_txd;
        end
        got_count++;
    end
endmodule : usart_remote

// [verification/usart_frame_path_tb.sv]
/* Self-checking bench of the serial frame path.
   Assumes the remote model and the bound checker are compiled beside it. */
`timescale 1ns/100ps
`include "usart_frame_defines.svh"

module usart_frame_path_tb;
    logic       i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_ack = 1'b0, i_glob = 1'b1;
    logic       i_clk, i_rxd, o_tx_done_irq, o_rx_irq, o_txd, o_txd_oe, o_rxd_owned;
    logic [2:0] i_addr = 3'h0;
    logic [1:0] xdiv = 2'h0;
    logic       xrun = 1'b0;
    logic [7:0] i_wdata = 8'h00, o_rdata;
    logic [8:0] v;
    int         fails = 0, compares = 0, cycles = 0, n;

    usart_frame_path usart_frame_path_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_enable(i_glob),
        .i_tx_done_irq_ack(i_ack), .o_tx_done_irq(o_tx_done_irq), .o_rx_irq(o_rx_irq),
        .o_udre_irq(), .i_rxd(i_rxd), .i_transfer_clock_pin(xdiv[1]), .o_txd(o_txd),
        .o_txd_oe(o_txd_oe), .o_rxd_owned(o_rxd_owned)
    );
    usart_remote #(.BIT(4)) usart_remote_inst (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Transfer clock of the remote side: one rising edge per bit, only while running.
    always @(posedge i_clk) begin
        if (xrun) xdiv <= xdiv + 2'h1;
    end

    // =========================================================================
    // Access and compare tasks
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [8:0] m);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = {1'b0, o_rdata} & m;
        @(posedge i_clk);
    endtask : rd

    // Status first, then the data byte, as software must do.
    task automatic pop(input logic [8:0] st, input logic [8:0] d);
        rd(`ADDR_STATUS, 9'h09C);
        chk(v, st);
        rd(`ADDR_DATA, 9'h0FF);
        chk(v, d);
    endtask : pop

    task automatic ack();
        for (n = 0; n < 200 && !o_tx_done_irq; n++) @(posedge i_clk);
        chk(9'(o_tx_done_irq), 9'h001);
        i_ack <= 1'b1;
        @(posedge i_clk);
        i_ack <= 1'b0;
        #1 chk(9'(o_tx_done_irq), 9'h000);
        @(posedge i_clk);
    endtask : ack

    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    // =========================================================================
    // Test sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(`ADDR_CONTROL, 9'h0FF);
        chk(v, {1'b0, `RST_CONTROL});
        rd(`ADDR_FORMAT, 9'h0FF);
        chk(v, {1'b0, `RST_FORMAT});
        $display("test registers done");
        wr(`ADDR_BAUD, 8'h03);
        wr(`ADDR_CONTROL, 8'h58);
        chk(9'(o_rxd_owned), 9'h001);
        for (int p = 0; p < 3; p++) begin
            wr(`ADDR_FORMAT, (p == 0) ? 8'h06 : ((p == 1) ? 8'h26 : 8'h36));
            wr(`ADDR_DATA, 8'h5B);
            for (n = 0; n < 400 && usart_remote_inst.got_count <= p; n++) @(posedge i_clk);
            chk(usart_remote_inst.got_bits, {(p == 0) | (^8'h5B ^ (p == 2)), 8'h5B});
        end
        ack();
        wr(`ADDR_DATA, 8'h81);
        for (n = 0; n < 20 && o_txd; n++) @(posedge i_clk);
        wr(`ADDR_DATA, 8'h7E);
        wr(`ADDR_CONTROL, 8'h50);
        chk(9'(o_txd_oe), 9'h001);
        for (n = 0; n < 400 && o_txd_oe; n++) @(posedge i_clk);
        chk(9'(usart_remote_inst.got_count), 9'h005);
        chk(usart_remote_inst.got_bits, 9'h17E);
        rd(`ADDR_STATUS, 9'h040);
        chk(v, 9'h040);
        ack();
        wr(`ADDR_DATA, 8'h11);
        repeat (40) @(posedge i_clk);
        chk(9'(usart_remote_inst.got_count), 9'h005);
        chk(9'(o_txd_oe), 9'h000);
        $display("test transmit done");
        wr(`ADDR_FORMAT, 8'h26);
        wr(`ADDR_CONTROL, 8'hD0);
        usart_remote_inst.send(9'h0A5, 8, 1'b1, ^8'hA5, 1'b1);
        usart_remote_inst.send(9'h03C, 8, 1'b1, ~^8'h3C, 1'b1);
        chk(9'(o_rx_irq), 9'h001);
        pop(9'h080, 9'h0A5);
        pop(9'h084, 9'h03C);
        for (int k = 0; k < 3; k++) begin
            usart_remote_inst.send(9'(8'h11 * (k + 1)), 8, 1'b1, ^8'(8'h11 * (k + 1)), 1'b1);
        end
        pop(9'h080, 9'h011);
        usart_remote_inst.send(9'h044, 8, 1'b1, ^8'h44, 1'b1);
        pop(9'h080, 9'h022);
        pop(9'h088, 9'h044);
        usart_remote_inst.send(9'h055, 8, 1'b1, ^8'h55, 1'b0);
        pop(9'h090, 9'h055);
        wr(`ADDR_FORMAT, 8'h07);
        usart_remote_inst.send(9'h1C3, 9, 1'b0, 1'b0, 1'b1);
        rd(`ADDR_CONTROL, 9'h004);
        chk(v, 9'h004);
        rd(`ADDR_DATA, 9'h0FF);
        chk(v, 9'h0C3);
        wr(`ADDR_FORMAT, 8'h00);
        usart_remote_inst.send(9'h015, 5, 1'b0, 1'b0, 1'b1);
        pop(9'h080, 9'h015);
        wr(`ADDR_FORMAT, 8'h46);
        xrun <= 1'b1;
        usart_remote_inst.send(9'h096, 8, 1'b0, 1'b0, 1'b1);
        xrun <= 1'b0;
        pop(9'h080, 9'h096);
        wr(`ADDR_FORMAT, 8'h00);
        $display("test receive done");
        usart_remote_inst.send(9'h00A, 5, 1'b0, 1'b0, 1'b1);
        i_glob <= 1'b0;
        @(posedge i_clk);
        #1 chk(9'(o_rx_irq), 9'h000);
        @(posedge i_clk);
        i_glob <= 1'b1;
        @(posedge i_clk);
        #1 chk(9'(o_rx_irq), 9'h001);
        @(posedge i_clk);
        wr(`ADDR_CONTROL, 8'hC0);
        rd(`ADDR_STATUS, 9'h080);
        chk(v, 9'h000);
        chk(9'(o_rx_irq), 9'h000);
        chk(9'(o_rxd_owned), 9'h000);
        $display("test flush done");
        print_verdict();
    end
endmodule : usart_frame_path_tb
